// ### hdl/acw_cfg.svh
// constants of the self-clocked watchdog control block
// Notes on behaviour
// - restart bit write-only, reads zero, restarts
// - timeout with reset enable resets in RUN
// - reset enable settable once until reset
// - wake interrupt output asserted only in STOP mode; irq output also in RUN
// - cyclic check runs only when enabled
// - timeout flag set at period end
// - writing one clears flag, restarts period
// - writing zero to flag changes nothing
// - rate bit: one 10 ms, zero 20 ms
// - reset clears every control register bit
// - counter runs only when a function enabled
// - reset function suspends in STOP, resumes later
// - STOP with interrupt enable wakes each period
// - cyclic wake samples hall pins, wakes on high
`ifndef ACW_CFG_SVH
`define ACW_CFG_SVH

// register indices; byte address is four times the index
`define ACW_CTL_IDX 6'h0a
`define ACW_STAT_IDX 6'h0b
`define ACW_MASK_IDX 6'h0c
`define ACW_HALL_IDX 6'h0d

// watchdog_control fields
`define ACW_RATE_BIT 0
`define ACW_FLAG_BIT 1
`define ACW_CC_BIT 2
`define ACW_IE_BIT 3
`define ACW_RE_BIT 4
`define ACW_RESTART_BIT 5
`define ACW_CTL_RESET 8'h00

// interrupt status and mask fields
`define ACW_EV_TIMEOUT 0
`define ACW_EV_HALL 1
`define ACW_EV_W 2

// hall configuration fields: pin enables low, irq enables from bit 4
`define ACW_HALL_IRQ_LSB 4

// timing
`define ACW_CLK_HZ 25000000
`define ACW_FAST_MS 10
`define ACW_SLOW_MS 20
`define ACW_RST_PULSE_CYC 16
`define ACW_HALL_SETTLE_CYC 8

`endif

// ### hdl/acw_pkg.sv
// types shared by the watchdog control block
package acw_pkg;
  typedef logic [7:0] acw_byte_t;
  typedef enum logic [1:0] {
    ACW_CHK_IDLE = 2'b00,
    ACW_CHK_POWER = 2'b01,
    ACW_CHK_SAMPLE = 2'b11
  } acw_chk_e;
endpackage

// ### hdl/acw_wd_if.sv
// interface between control, timeout timer and cyclic checker
`timescale 1ns/1ns
`default_nettype none
interface acw_wd_if #(
  parameter int N = 3
);
  logic ce;
  logic run;
  logic restart;
  logic freeze;
  logic rate;
  logic tick;
  logic chk_start;
  logic [N-1:0] hall_en;
  logic wake;
  modport ctl (output ce, run, restart, freeze, rate, chk_start, hall_en,
               input tick, wake);
  modport tmr (input ce, run, restart, freeze, rate, output tick);
  modport chk (input ce, chk_start, hall_en, output wake);
endinterface
`default_nettype wire

// ### hdl/acw_timer.sv
// timeout period counter of the watchdog oscillator
`timescale 1ns/1ns
`default_nettype none
module acw_timer
  import acw_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int unsigned FAST_CYCLES = 250000,
  parameter int unsigned SLOW_CYCLES = 500000
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  acw_wd_if.tmr wd
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic tick;
  logic next_tick;
  logic [CNT_W-1:0] end_val;

  always_comb begin
    end_val = wd.rate ? CNT_W'(FAST_CYCLES - 1) : CNT_W'(SLOW_CYCLES - 1);
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!wd.run) begin
      next_cnt = '0;
    end else if (wd.restart) begin
      next_cnt = '0;
    end else if (wd.freeze) begin
      next_cnt = cnt;
    end else if (cnt >= end_val) begin
      // >= so a rate change to the shorter period cannot overshoot
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (wd.ce) begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  assign wd.tick = tick;
endmodule
`default_nettype wire

// ### hdl/acw_hall_check.sv
// cyclic check: powers hall inputs, samples them and the analog input
`timescale 1ns/1ns
`default_nettype none
`include "acw_cfg.svh"
module acw_hall_check
  import acw_pkg::*;
#(
  parameter int N = 3,
  parameter int SETTLE = `ACW_HALL_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [N-1:0] hall_pin_i,
  output logic [N-1:0] hall_power_o,
  output logic analog_sample_o,
  acw_wd_if.chk wd
);
  acw_chk_e state;
  acw_chk_e next_state;
  logic [7:0] settle;
  logic [7:0] next_settle;
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic wake;
  logic next_wake;
  logic [N-1:0] next_power;
  logic next_sample;

  always_comb begin
    next_state = state;
    next_settle = settle;
    next_wake = 1'b0;
    next_power = '0;
    next_sample = 1'b0;
    case (state)
      ACW_CHK_IDLE: begin
        if (wd.chk_start) begin
          next_state = ACW_CHK_POWER;
          next_settle = 8'(SETTLE - 1);
          next_power = wd.hall_en;
        end
      end
      ACW_CHK_POWER: begin
        next_power = wd.hall_en;
        if (settle == 8'h00) begin
          next_state = ACW_CHK_SAMPLE;
          next_sample = 1'b1;
        end else begin
          next_settle = settle - 8'h01;
        end
      end
      ACW_CHK_SAMPLE: begin
        next_state = ACW_CHK_IDLE;
        next_wake = |(sync2 & wd.hall_en);
      end
      default: begin
        next_state = ACW_CHK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ACW_CHK_IDLE;
      settle <= 8'h00;
      sync1 <= '0;
      sync2 <= '0;
      wake <= 1'b0;
      hall_power_o <= '0;
      analog_sample_o <= 1'b0;
    end else if (wd.ce) begin
      state <= next_state;
      settle <= next_settle;
      sync1 <= hall_pin_i;
      sync2 <= sync1;
      wake <= next_wake;
      hall_power_o <= next_power;
      analog_sample_o <= next_sample;
    end
  end

  assign wd.wake = wake;
endmodule
`default_nettype wire

// ### hdl/acw_top.sv
// self-clocked watchdog: control register, Avalon-MM slave, reset/wake
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "acw_cfg.svh"
module acw_top
  import acw_pkg::*;
#(
  parameter int N = 3,
  parameter int unsigned FAST_CYCLES = `ACW_FAST_MS * (`ACW_CLK_HZ / 1000),
  parameter int unsigned SLOW_CYCLES = `ACW_SLOW_MS * (`ACW_CLK_HZ / 1000),
  parameter int RST_PULSE = `ACW_RST_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic stop_mode_i,
  input wire logic [N-1:0] hall_pin_i,
  output logic [N-1:0] hall_power_o,
  output logic analog_sample_o,
  output logic wd_reset_n_o,
  output logic wake_irq_n_o,
  output logic irq_o
);
  function automatic logic acw_hit(input logic [7:0] addr,
                                   input logic [5:0] idx);
    acw_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  acw_wd_if #(.N(N)) wd ();

  // control register fields
  logic rate;
  logic flag;
  logic cc;
  logic ie;
  logic re;
  logic next_rate;
  logic next_flag;
  logic next_cc;
  logic next_ie;
  logic next_re;
  // interrupt and hall configuration
  logic [`ACW_EV_W-1:0] stat;
  logic [`ACW_EV_W-1:0] mask;
  logic [`ACW_EV_W-1:0] next_stat;
  logic [`ACW_EV_W-1:0] next_mask;
  logic [N-1:0] pin_en;
  logic [N-1:0] pin_irq_en;
  logic [N-1:0] next_pin_en;
  logic [N-1:0] next_pin_irq_en;
  logic hall_hit;
  logic next_hall_hit;
  // reset pulse and interrupt outputs
  logic [7:0] rst_cnt;
  logic [7:0] next_rst_cnt;
  logic next_wd_reset_n;
  logic next_wake_irq_n;
  logic next_irq;
  // bus
  logic next_wait;
  logic [31:0] next_rdata;
  logic req;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic ctl_wr;
  logic restart;
  logic flag_clr;
  acw_byte_t ctl_rd;
  acw_byte_t wbyte;

  always_comb begin
    req = avs_read_i | avs_write_i;
    // a request is taken on the edge where waitrequest is already low
    acc = req & ~avs_waitrequest_o;
    wr_acc = acc & avs_write_i & avs_byteenable_i[0];
    rd_acc = acc & avs_read_i;
    wbyte = avs_writedata_i[7:0];
    ctl_wr = wr_acc & acw_hit(avs_address_i, `ACW_CTL_IDX);
    restart = ctl_wr & wbyte[`ACW_RESTART_BIT];
    flag_clr = ctl_wr & wbyte[`ACW_FLAG_BIT];

    next_rate = ctl_wr ? wbyte[`ACW_RATE_BIT] : rate;
    next_cc = ctl_wr ? wbyte[`ACW_CC_BIT] : cc;
    next_ie = ctl_wr ? wbyte[`ACW_IE_BIT] : ie;
    // once set it sticks until reset; a zero write cannot clear it
    next_re = re | (ctl_wr & wbyte[`ACW_RE_BIT]);
    // a timeout in the same cycle as the clear keeps the flag set
    if (wd.tick) begin
      next_flag = 1'b1;
    end else if (flag_clr) begin
      next_flag = 1'b0;
    end else begin
      next_flag = flag;
    end

    next_mask = mask;
    next_pin_en = pin_en;
    next_pin_irq_en = pin_irq_en;
    if (wr_acc && acw_hit(avs_address_i, `ACW_MASK_IDX)) begin
      next_mask = wbyte[`ACW_EV_W-1:0];
    end else if (wr_acc && acw_hit(avs_address_i, `ACW_HALL_IDX)) begin
      next_pin_en = wbyte[N-1:0];
      next_pin_irq_en = wbyte[`ACW_HALL_IRQ_LSB +: N];
    end

    next_stat = stat;
    if (rd_acc && acw_hit(avs_address_i, `ACW_STAT_IDX)) begin
      next_stat = '0;
    end
    next_stat[`ACW_EV_TIMEOUT] = next_stat[`ACW_EV_TIMEOUT] | wd.tick;
    next_stat[`ACW_EV_HALL] = next_stat[`ACW_EV_HALL] | wd.wake;
    next_irq = |(next_stat & next_mask);

    // a hall wake holds until the system is back in RUN mode
    if (wd.wake) begin
      next_hall_hit = 1'b1;
    end else if (!stop_mode_i) begin
      next_hall_hit = 1'b0;
    end else begin
      next_hall_hit = hall_hit;
    end
    next_wake_irq_n = ~(stop_mode_i &
                        ((ie & next_flag) | next_hall_hit));

    next_rst_cnt = rst_cnt;
    if (wd.tick && re && !stop_mode_i) begin
      next_rst_cnt = 8'(RST_PULSE);
    end else if (rst_cnt != 8'h00) begin
      next_rst_cnt = rst_cnt - 8'h01;
    end
    next_wd_reset_n = (next_rst_cnt == 8'h00);

    // one wait cycle, then the answer for one cycle
    next_wait = ~(req & avs_waitrequest_o);
    ctl_rd = 8'h00;
    ctl_rd[`ACW_RATE_BIT] = rate;
    ctl_rd[`ACW_FLAG_BIT] = flag;
    ctl_rd[`ACW_CC_BIT] = cc;
    ctl_rd[`ACW_IE_BIT] = ie;
    ctl_rd[`ACW_RE_BIT] = re;
    next_rdata = 32'h0000_0000;
    if (acw_hit(avs_address_i, `ACW_CTL_IDX)) begin
      next_rdata[7:0] = ctl_rd;
    end else if (acw_hit(avs_address_i, `ACW_STAT_IDX)) begin
      next_rdata[`ACW_EV_W-1:0] = next_stat;
    end else if (acw_hit(avs_address_i, `ACW_MASK_IDX)) begin
      next_rdata[`ACW_EV_W-1:0] = mask;
    end else if (acw_hit(avs_address_i, `ACW_HALL_IDX)) begin
      next_rdata[N-1:0] = pin_en;
      next_rdata[`ACW_HALL_IRQ_LSB +: N] = pin_irq_en;
    end
    if (!(avs_read_i && avs_waitrequest_o)) begin
      next_rdata = avs_readdata_o;
    end
  end

  // timer and checker steering
  assign wd.ce = ce_i;
  assign wd.run = ie | re | cc;
  assign wd.restart = restart | flag_clr;
  // in STOP only the reset function is enabled: hold the count
  assign wd.freeze = stop_mode_i & ~ie & ~cc;
  assign wd.rate = rate;
  assign wd.chk_start = wd.tick & stop_mode_i & cc;
  assign wd.hall_en = pin_en & pin_irq_en;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate <= 1'(`ACW_CTL_RESET >> `ACW_RATE_BIT);
      flag <= 1'(`ACW_CTL_RESET >> `ACW_FLAG_BIT);
      cc <= 1'(`ACW_CTL_RESET >> `ACW_CC_BIT);
      ie <= 1'(`ACW_CTL_RESET >> `ACW_IE_BIT);
      re <= 1'(`ACW_CTL_RESET >> `ACW_RE_BIT);
      stat <= '0;
      mask <= '0;
      pin_en <= '0;
      pin_irq_en <= '0;
      hall_hit <= 1'b0;
      rst_cnt <= 8'h00;
      wd_reset_n_o <= 1'b1;
      wake_irq_n_o <= 1'b1;
      irq_o <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rate <= next_rate;
      flag <= next_flag;
      cc <= next_cc;
      ie <= next_ie;
      re <= next_re;
      stat <= next_stat;
      mask <= next_mask;
      pin_en <= next_pin_en;
      pin_irq_en <= next_pin_irq_en;
      hall_hit <= next_hall_hit;
      rst_cnt <= next_rst_cnt;
      wd_reset_n_o <= next_wd_reset_n;
      wake_irq_n_o <= next_wake_irq_n;
      irq_o <= next_irq;
      avs_waitrequest_o <= next_wait;
      avs_readdata_o <= next_rdata;
    end
  end

  acw_timer #(
    .CNT_W(32),
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wd(wd.tmr)
  );

  acw_hall_check #(
    .N(N),
    .SETTLE(`ACW_HALL_SETTLE_CYC)
  ) u_check (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .hall_pin_i(hall_pin_i),
    .hall_power_o(hall_power_o),
    .analog_sample_o(analog_sample_o),
    .wd(wd.chk)
  );
endmodule
`default_nettype wire

// ### sim/acw_top_asserts.sv
// port assertions for the self-clocked watchdog block
`timescale 1ns/1ns
`default_nettype none
module acw_top_asserts #(
  parameter int N = 3
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic stop_mode_i,
  input wire logic [N-1:0] hall_power_o,
  input wire logic analog_sample_o,
  input wire logic wd_reset_n_o,
  input wire logic wake_irq_n_o
);
  logic pwr;
  assign pwr = |hall_power_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_bus_answer: assert property ((avs_read_i || avs_write_i) && ce_i &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("answer late");
  a_wait_single: assert property (!avs_waitrequest_o && ce_i |=>
    avs_waitrequest_o) else $error("wait low too long");
  a_ctl_zero: assert property (avs_read_i &&
    !avs_waitrequest_o && avs_address_i == 8'h28 |->
    avs_readdata_o[7:5] == 3'h0) else $error("control top bits set");
  a_reset_run_only: assert property (
    $fell(wd_reset_n_o) |-> !$past(stop_mode_i)) else $error("reset in stop");
  a_reset_pulse: assert property ($fell(wd_reset_n_o) |->
    !wd_reset_n_o [*8]) else $error("reset pulse short");
  a_wake_stop_only: assert property (!wake_irq_n_o |->
    $past(stop_mode_i)) else $error("wake outside stop");
  a_check_in_stop: assert property ($rose(pwr) |->
    $past(stop_mode_i)) else $error("check outside stop");
  a_power_sample: assert property ($rose(pwr) |-> pwr [*8] ##[0:2]
    analog_sample_o) else $error("sample missing");
  a_sample_pulse: assert property (analog_sample_o |=>
    !analog_sample_o) else $error("sample too long");
  c_reset: cover property ($fell(wd_reset_n_o));
  c_wake: cover property ($fell(wake_irq_n_o));
  c_sample: cover property (analog_sample_o);
endmodule
`default_nettype wire

// ### sim/acw_cpu.sv
// bus master model of the embedded microcontroller core
`timescale 1ns/1ns
`default_nettype none
module acw_cpu (
  input wire logic clk_i,
  input wire logic wait_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o
);
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0;
  end
  // request held until waitrequest seen low; the bound cuts a hang short
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= !w;
    wr_o <= w;
    wdata_o <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_i !== 1'b0 && n < 20);
    q = rdata_i[7:0];
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    if (n >= 20) tb.hang();
  endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the self-clocked watchdog block
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [7:0] CTL = 8'h28;
  localparam logic [7:0] STAT = 8'h2c;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic stop_mode_i = 1'b0;
  logic [2:0] hall_pin_i = 3'h0;
  logic [7:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [2:0] hall_power_o;
  logic analog_sample_o;
  logic wd_reset_n_o;
  logic wake_irq_n_o;
  logic irq_o;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  always #20 clk_i = ~clk_i;
  // short periods keep the run brief; the timeout waits below scale from them
  acw_top #(.N(3), .FAST_CYCLES(40), .SLOW_CYCLES(80), .RST_PULSE(16)) dut (
    .clk_i, .reset_n_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
    .avs_waitrequest_o, .stop_mode_i, .hall_pin_i, .hall_power_o,
    .analog_sample_o, .wd_reset_n_o, .wake_irq_n_o, .irq_o);
  acw_cpu cpu (.clk_i, .wait_i(avs_waitrequest_o), .rdata_i(avs_readdata_o),
    .addr_o(avs_address_i), .rd_o(avs_read_i), .wr_o(avs_write_i),
    .wdata_o(avs_writedata_i));
  task final_report;
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task hang;
    miscompares++;
    final_report();
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    cpu.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task wrt(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(1'b1, a, d, q);
  endtask
  task wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task do_reset;
    reset_n_i <= 1'b0;
    wt(3);
    reset_n_i <= 1'b1;
    wt(1);
  endtask
  initial begin
    do_reset();
    rdc(CTL, 8'h00);
    wrt(8'h3c, 8'hff);
    rdc(8'h3c, 8'h00);
    wt(100);
    rdc(CTL, 8'h00);
    rdc(STAT, 8'h00);
    wrt(CTL, 8'h09);
    // clock enable low must hold the count, so the period starts late
    ce_i <= 1'b0;
    wt(20);
    ce_i <= 1'b1;
    wt(25);
    rdc(CTL, 8'h09);
    wt(20);
    rdc(CTL, 8'h0b);
    wrt(CTL, 8'h09);
    rdc(CTL, 8'h0b);
    wrt(CTL, 8'h0b);
    rdc(CTL, 8'h09);
    wrt(CTL, 8'h08);
    wt(50);
    rdc(CTL, 8'h08);
    wt(30);
    rdc(CTL, 8'h0a);
    wrt(CTL, 8'h0a);
    // restarts spaced below the slow period must keep the flag clear
    repeat (3) begin
      wt(50);
      wrt(CTL, 8'h28);
    end
    rdc(CTL, 8'h08);
    rdc(STAT, 8'h01);
    rdc(STAT, 8'h00);
    wrt(8'h30, 8'h01);
    wt(90);
    chk({7'h0, irq_o}, 8'h01);
    rdc(STAT, 8'h01);
    wt(2);
    chk({7'h0, irq_o}, 8'h00);
    wrt(8'h30, 8'h00);
    wt(85);
    chk({7'h0, irq_o}, 8'h00);
    rdc(STAT, 8'h01);
    chk({7'h0, wake_irq_n_o}, 8'h01);
    stop_mode_i <= 1'b1;
    wt(3);
    chk({7'h0, wake_irq_n_o}, 8'h00);
    chk({5'h0, hall_power_o}, 8'h00);
    wrt(CTL, 8'h0a);
    wt(2);
    chk({7'h0, wake_irq_n_o}, 8'h01);
    wt(85);
    chk({7'h0, wake_irq_n_o}, 8'h00);
    stop_mode_i <= 1'b0;
    wt(2);
    chk({7'h0, wake_irq_n_o}, 8'h01);
    wrt(CTL, 8'h12);
    wrt(CTL, 8'h00);
    rdc(CTL, 8'h10);
    stop_mode_i <= 1'b1;
    wt(100);
    stop_mode_i <= 1'b0;
    n = 0;
    while (wd_reset_n_o !== 1'b0 && n < 100) begin
      wt(1);
      n++;
    end
    if (n >= 100) hang();
    chk({7'h0, n >= 65 && n <= 80}, 8'h01);
    n = 0;
    while (wd_reset_n_o === 1'b0 && n < 40) begin
      wt(1);
      n++;
    end
    if (n >= 40) hang();
    chk(n[7:0], 8'h10);
    do_reset();
    rdc(CTL, 8'h00);
    wrt(8'h34, 8'h11);
    hall_pin_i <= 3'h1;
    wrt(CTL, 8'h05);
    stop_mode_i <= 1'b1;
    n = 0;
    while (hall_power_o !== 3'h1 && n < 60) begin
      wt(1);
      n++;
    end
    if (n >= 60) hang();
    wt(8);
    chk({7'h0, analog_sample_o}, 8'h01);
    wt(6);
    chk({7'h0, wake_irq_n_o}, 8'h00);
    rdc(STAT, 8'h03);
    stop_mode_i <= 1'b0;
    wt(2);
    chk({7'h0, wake_irq_n_o}, 8'h01);
    final_report();
  end
endmodule
bind acw_top acw_top_asserts #(.N(N)) u_chk (.clk_i, .reset_n_i, .ce_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .stop_mode_i, .hall_power_o, .analog_sample_o,
  .wd_reset_n_o, .wake_irq_n_o);
`default_nettype wire
